// File: rtl/ilc_clock.sv
// interval timer and line-frequency ticker on the byte-wide i/o bus
`timescale 1ns/1ns
module ilc_clock (
  // clock and reset
  input  wire logic        clock,
  input  wire logic        rst_n,
  // i/o bus, one-cycle strobes
  input  wire logic [7:0]  devAddr,
  input  wire logic [15:0] wrData,
  input  wire logic        half,
  input  wire logic        wrStb,
  input  wire logic        rdStb,
  input  wire logic        cmdStb,
  input  wire logic        senseStb,
  input  wire logic        ackStb,
  // bus answers
  output logic      [15:0] rdData_r,
  output logic             rdValid_r,
  output logic             irqReq_r,
  output logic      [7:0]  irqDev_r,
  // pins
  input  wire logic        useExtTime,
  input  wire logic        extTime_n,
  input  wire logic        acLine
);
  import ilc_pkg::*;

  typedef struct packed {
    logic        extS1;
    logic        extS2;
    logic        extS3;
    logic        acS1;
    logic        acS2;
    logic        acS3;
    logic        selS1;
    logic        selS2;
    logic [3:0]  tbDiv;
    logic [9:0]  preCnt;
    logic [11:0] cnt;
    logic [3:0]  resSel;
    logic        running;
    logic [7:0]  bufHi;
    logic [7:0]  bufLo;
    logic        bytePos;
    logic        loadPend;
    logic        ovr;
    logic        timerQ;
    logic        timerEn;
    logic        tickQ;
    logic        tickEn;
    logic [11:0] rdSnap;
    logic [15:0] rdData;
    logic        rdValid;
    logic        irqReq;
    logic [7:0]  irqDev;
  } ilc_state_t;

  ilc_state_t st_r;
  ilc_state_t st_nxt;
  logic       timerSel;
  logic       tickSel;
  logic       tbTick;
  logic       termCnt;
  logic       startCmd;
  logic [11:0] bufCount;

  // prescaler reload for the highest-numbered resolution bit that is set
  function automatic logic [9:0] resLimit(input logic [3:0] r);
    logic [9:0] v;
    v = ILC_PRE3;
    if (r[3]) begin
      v = ILC_PRE0;
    end else if (r[2]) begin
      v = ILC_PRE1;
    end else if (r[1]) begin
      v = ILC_PRE2;
    end
    return v;
  endfunction

  assign timerSel = (devAddr == ILC_TIMER_ADDR);
  assign tickSel  = (devAddr == ILC_TICKER_ADDR);
  assign bufCount = {st_r.bufHi[3:0], st_r.bufLo};
  assign startCmd = cmdStb && timerSel && wrData[ILC_CMD_RUN_POS];

  always_comb begin
    st_nxt = st_r;
    st_nxt.extS1 = extTime_n;
    st_nxt.extS2 = st_r.extS1;
    st_nxt.extS3 = st_r.extS2;
    st_nxt.acS1 = acLine;
    st_nxt.acS2 = st_r.acS1;
    st_nxt.acS3 = st_r.acS2;
    st_nxt.selS1 = useExtTime;
    st_nxt.selS2 = st_r.selS1;
    st_nxt.rdValid = 1'b0;
    // timebase: internal divider or falling edge of external input
    if (st_r.tbDiv == ILC_TB_LAST) begin
      st_nxt.tbDiv = 4'h0;
    end else begin
      st_nxt.tbDiv = st_r.tbDiv + 4'h1;
    end
    if (st_r.selS2) begin
      tbTick = st_r.extS3 && !st_r.extS2;
    end else begin
      tbTick = (st_r.tbDiv == ILC_TB_LAST);
    end
    // prescaler and down-counter
    termCnt = 1'b0;
    if (st_r.running && tbTick) begin
      if (st_r.preCnt == 10'h000) begin
        st_nxt.preCnt = resLimit(st_r.resSel);
        if (st_r.cnt <= 12'h001) begin
          termCnt = 1'b1;
          st_nxt.cnt = bufCount;
          if (st_r.loadPend) begin
            st_nxt.running = 1'b0;
          end
        end else begin
          st_nxt.cnt = st_r.cnt - 12'h001;
        end
      end else begin
        st_nxt.preCnt = st_r.preCnt - 10'h001;
      end
    end
    // data writes, the running count is left alone
    if (wrStb && timerSel) begin
      if (half) begin
        st_nxt.bufHi = wrData[15:8];
        st_nxt.bufLo = wrData[7:0];
        st_nxt.loadPend = 1'b0;
      end else if (!st_r.bytePos) begin
        st_nxt.bufHi = wrData[7:0];
        st_nxt.loadPend = 1'b1;
        st_nxt.bytePos = 1'b1;
      end else begin
        st_nxt.bufLo = wrData[7:0];
        st_nxt.loadPend = 1'b0;
        st_nxt.bytePos = 1'b0;
      end
    end
    // data reads
    if (rdStb && timerSel) begin
      st_nxt.rdValid = 1'b1;
      if (half) begin
        st_nxt.rdData = {4'h0, st_r.cnt};
      end else if (!st_r.bytePos) begin
        st_nxt.rdSnap = st_r.cnt;
        st_nxt.rdData = {12'h000, st_r.cnt[11:8]};
        st_nxt.bytePos = 1'b1;
      end else begin
        st_nxt.rdData = {8'h00, st_r.rdSnap[7:0]};
        st_nxt.bytePos = 1'b0;
      end
    end
    if ((rdStb || senseStb) && tickSel) begin
      st_nxt.rdValid = 1'b1;
      st_nxt.rdData = 16'h0000;
    end
    if (senseStb && timerSel) begin
      st_nxt.rdValid = 1'b1;
      st_nxt.rdData = 16'h0000;
      st_nxt.rdData[ILC_STAT_OVR_POS] = st_r.ovr;
      st_nxt.ovr = 1'b0;
    end
    // commands
    if (cmdStb && timerSel) begin
      if (wrData[ILC_CMD_MASK_POS]) begin
        st_nxt.timerEn = 1'b0;
      end
      if (wrData[ILC_CMD_UNMASK_POS]) begin
        st_nxt.timerEn = 1'b1;
      end
      if (wrData[ILC_CMD_RUN_POS]) begin
        st_nxt.resSel = st_r.bufHi[7:4];
        st_nxt.running = (st_r.bufHi[7:4] != 4'h0);
        st_nxt.cnt = bufCount;
        st_nxt.preCnt = resLimit(st_r.bufHi[7:4]);
      end
    end
    if (cmdStb && tickSel) begin
      if (wrData[ILC_CMD_MASK_POS]) begin
        st_nxt.tickEn = 1'b0;
      end
      if (wrData[ILC_CMD_UNMASK_POS]) begin
        st_nxt.tickEn = 1'b1;
      end
    end
    // acknowledge goes to the highest requester and returns its address
    if (ackStb) begin
      if (st_r.timerQ && st_r.timerEn) begin
        st_nxt.timerQ = 1'b0;
        st_nxt.ovr = 1'b0;
        st_nxt.rdValid = 1'b1;
        st_nxt.rdData = {8'h00, ILC_TIMER_ADDR};
      end else if (st_r.tickQ && st_r.tickEn) begin
        st_nxt.tickQ = 1'b0;
        st_nxt.rdValid = 1'b1;
        st_nxt.rdData = {8'h00, ILC_TICKER_ADDR};
      end
    end
    // hardware sets last so a same-cycle clear never loses an event
    if (termCnt) begin
      st_nxt.timerQ = 1'b1;
      if (st_r.loadPend) begin
        st_nxt.ovr = 1'b1;
      end
    end
    if (st_r.acS2 != st_r.acS3) begin
      st_nxt.tickQ = 1'b1;
    end
    st_nxt.irqReq = (st_nxt.timerQ && st_nxt.timerEn) || (st_nxt.tickQ && st_nxt.tickEn);
    st_nxt.irqDev = (st_nxt.timerQ && st_nxt.timerEn) ? ILC_TIMER_ADDR : ILC_TICKER_ADDR;
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign rdData_r  = st_r.rdData;
  assign rdValid_r = st_r.rdValid;
  assign irqReq_r  = st_r.irqReq;
  assign irqDev_r  = st_r.irqDev;

  ack_priority_a: assert property (@(posedge clock) disable iff (!rst_n)
    (ackStb && st_r.timerQ && st_r.timerEn && st_r.tickQ && st_r.tickEn)
    |=> st_r.tickQ && rdData_r == {8'h00, ILC_TIMER_ADDR})
    else $error("acknowledge did not favour the timer");
  start_load_a: assert property (@(posedge clock) disable iff (!rst_n)
    (startCmd && st_r.bufHi[7:4] != 4'h0 && !wrStb)
    |=> st_r.running && st_r.cnt == $past(bufCount) && $stable(st_r.bufLo))
    else $error("start did not load the counter");
  reload_cycle_a: assert property (@(posedge clock) disable iff (!rst_n)
    (termCnt && !startCmd) |=> st_r.timerQ && st_r.cnt == $past(bufCount))
    else $error("terminal count did not reload and queue");
  count_step_a: assert property (@(posedge clock) disable iff (!rst_n)
    ($changed(st_r.cnt) && !$past(startCmd)) |-> $past(tbTick && st_r.preCnt == 10'h000))
    else $error("count moved without a resolution period");
  overrun_stop_a: assert property (@(posedge clock) disable iff (!rst_n)
    (termCnt && st_r.loadPend && !startCmd) |=> st_r.ovr && !st_r.running ##1 !st_r.running)
    else $error("split load overrun did not stop the count");
  overrun_clear_a: assert property (@(posedge clock) disable iff (!rst_n)
    (senseStb && timerSel && !termCnt) |=> !st_r.ovr && rdValid_r)
    else $error("status read did not clear overrun");
  byte_toggle_a: assert property (@(posedge clock) disable iff (!rst_n)
    ((wrStb || rdStb) && timerSel && !half) |=> st_r.bytePos != $past(st_r.bytePos))
    else $error("byte position did not toggle");
  ticker_quiet_a: assert property (@(posedge clock) disable iff (!rst_n)
    (rdStb && tickSel && !ackStb) |=> rdValid_r && rdData_r == 16'h0000)
    else $error("ticker read returned data");
  no_res_stop_a: assert property (@(posedge clock) disable iff (!rst_n)
    (startCmd && st_r.bufHi[7:4] == 4'h0) |=> !st_r.running)
    else $error("start without resolution kept running");
  irq_gate_a: assert property (@(posedge clock) disable iff (!rst_n)
    (ackStb && st_r.timerQ && st_r.timerEn && !termCnt
      && !(st_r.tickEn && (st_r.tickQ || st_r.acS2 != st_r.acS3)))
    |=> !irqReq_r)
    else $error("request stayed after acknowledge");
  mask_cmd_a: assert property (@(posedge clock) disable iff (!rst_n)
    (cmdStb && timerSel && wrData[ILC_CMD_MASK_POS] && !wrData[ILC_CMD_UNMASK_POS])
    |=> !st_r.timerEn)
    else $error("mask command left the timer interrupt enabled");
  unmask_cmd_a: assert property (@(posedge clock) disable iff (!rst_n)
    (cmdStb && timerSel && wrData[ILC_CMD_UNMASK_POS])
    |=> st_r.timerEn)
    else $error("unmask command left the timer interrupt disabled");
  tick_edge_a: assert property (@(posedge clock) disable iff (!rst_n)
    (st_r.acS2 != st_r.acS3)
    |=> st_r.tickQ)
    else $error("mains edge did not queue a tick");
  tick_mask_a: assert property (@(posedge clock) disable iff (!rst_n)
    (cmdStb && tickSel && wrData[ILC_CMD_MASK_POS] && !wrData[ILC_CMD_UNMASK_POS])
    |=> !st_r.tickEn)
    else $error("mask command left the ticker interrupt enabled");
  load_keeps_count_a: assert property (@(posedge clock) disable iff (!rst_n)
    (wrStb && timerSel && !(st_r.running && tbTick && st_r.preCnt == 10'h000))
    |=> $stable(st_r.cnt))
    else $error("buffer load disturbed the running count");
  count_readback_a: assert property (@(posedge clock) disable iff (!rst_n)
    (rdStb && timerSel && half)
    |=> rdValid_r && rdData_r == {4'h0, $past(st_r.cnt)} && $stable({st_r.bufHi, st_r.bufLo}))
    else $error("halfword readback returned a wrong count");
endmodule

// File: inc/ilc_pkg.sv
// constants for the interval timer and line-frequency ticker
package ilc_pkg;
  // device addresses on the byte bus
  localparam logic [7:0]  ILC_TIMER_ADDR   = 8'h6c;
  localparam logic [7:0]  ILC_TICKER_ADDR  = 8'h6d;
  // clock and timebase
  localparam int          ILC_CLK_PERIOD_NS = 100;
  localparam int          ILC_TB_PERIOD_NS  = 1000;
  localparam int          ILC_TB_DIV        = ILC_TB_PERIOD_NS / ILC_CLK_PERIOD_NS;
  localparam logic [3:0]  ILC_TB_LAST       = 4'(ILC_TB_DIV - 1);
  // resolution periods in microseconds, counted in 1 us timebase ticks
  localparam int          ILC_RES0_US = 1000;
  localparam int          ILC_RES1_US = 100;
  localparam int          ILC_RES2_US = 10;
  localparam int          ILC_RES3_US = 1;
  localparam int          ILC_TB_US   = ILC_TB_PERIOD_NS / 1000;
  localparam logic [9:0]  ILC_PRE0    = 10'(ILC_RES0_US / ILC_TB_US - 1);
  localparam logic [9:0]  ILC_PRE1    = 10'(ILC_RES1_US / ILC_TB_US - 1);
  localparam logic [9:0]  ILC_PRE2    = 10'(ILC_RES2_US / ILC_TB_US - 1);
  localparam logic [9:0]  ILC_PRE3    = 10'(ILC_RES3_US / ILC_TB_US - 1);
  // field positions (bit 0 is the least significant data bit)
  localparam int          ILC_CMD_MASK_POS   = 7;
  localparam int          ILC_CMD_UNMASK_POS = 6;
  localparam int          ILC_CMD_RUN_POS    = 5;
  localparam int          ILC_STAT_OVR_POS   = 3;
  // values after reset
  localparam logic [11:0] ILC_COUNT_RST = 12'h000;
  localparam logic [7:0]  ILC_BYTE_RST  = 8'h00;
endpackage

// File: bench/ilc_host_model.sv
// host model issuing channel strobes to the clock block
`timescale 1ns/1ns
module ilc_host_model (
  // clock
  input  wire logic        clock,
  // requests: wr, rd, cmd, sense, ack
  output logic      [7:0]  devAddr,
  output logic      [15:0] wrData,
  output logic             half,
  output logic      [4:0]  stb,
  // answers
  input  wire logic [15:0] rdData_r,
  input  wire logic        rdValid_r
);
  initial begin
    devAddr = 8'h00;
    wrData  = 16'h0000;
    half    = 1'b0;
    stb     = 5'h00;
  end
  // one strobe cycle; afterwards devAddr and wrData show the inverse of their last value
  task automatic op(input logic [4:0] k, input logic [7:0] a, input logic [15:0] d,
                    input logic hw, output logic [15:0] rd, output logic v);
    @(negedge clock);
    devAddr <= a;
    wrData  <= d;
    half    <= hw;
    stb     <= k;
    @(negedge clock);
    v  = rdValid_r;
    rd = rdData_r;
    stb     <= 5'h00;
    devAddr <= ~a;
    wrData  <= ~d;
  endtask
  // byte pair, resolution byte first
  task automatic wr2(input logic [7:0] a, input logic [15:0] d);
    logic [15:0] r;
    logic        v;
    op(5'h10, a, {8'h00, d[15:8]}, 1'b0, r, v);
    op(5'h10, a, {8'h00, d[7:0]}, 1'b0, r, v);
  endtask
endmodule

// File: bench/interval_and_line_clock_tb.sv
// self-checking bench for the interval timer and line-frequency ticker
`timescale 1ns/1ns
module interval_and_line_clock_tb;
  import ilc_pkg::*;
  localparam logic [4:0] WR = 5'h10;
  localparam logic [4:0] RD = 5'h08;
  localparam logic [4:0] CMD = 5'h04;
  localparam logic [4:0] SNS = 5'h02;
  localparam logic [4:0] ACK = 5'h01;
  localparam logic [7:0] TA = ILC_TIMER_ADDR;
  localparam logic [7:0] KA = ILC_TICKER_ADDR;
  logic        clock, rst_n, acLine, half, rdValid_r, irqReq_r, v;
  logic [7:0]  devAddr, irqDev_r;
  logic [15:0] wrData, rdData_r, rd, rb;
  logic [4:0]  stb;
  logic        useExt    = 1'b0;
  logic        extTime_n = 1'b1;
  logic [4:0]  extPh     = 5'h00;
  int          n_mismatch = 0;
  int          cmp_count = 0;
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin n_mismatch++; \
  $display("Error %s expected %0h seen %0h", n, e, g); end end
  ilc_clock uut (.clock(clock), .rst_n(rst_n), .devAddr(devAddr), .wrData(wrData),
    .half(half), .wrStb(stb[4]), .rdStb(stb[3]), .cmdStb(stb[2]), .senseStb(stb[1]),
    .ackStb(stb[0]), .rdData_r(rdData_r), .rdValid_r(rdValid_r), .irqReq_r(irqReq_r),
    .irqDev_r(irqDev_r), .useExtTime(useExt), .extTime_n(extTime_n), .acLine(acLine));
  ilc_host_model host (.clock(clock), .devAddr(devAddr), .wrData(wrData), .half(half),
    .stb(stb), .rdData_r(rdData_r), .rdValid_r(rdValid_r));
  // external timebase: one short low pulse every 20 cycles while selected
  always @(negedge clock) begin
    extPh     <= (extPh == 5'h13) ? 5'h00 : extPh + 5'h01;
    extTime_n <= !(useExt && extPh < 5'h04);
  end
  task automatic wait_irq(input int lim, output int n);
    n = 0;
    while (irqReq_r !== 1'b1 && n < lim) begin
      @(negedge clock);
      n++;
    end
  endtask
  task automatic t_basic();
    host.op(SNS, TA, 16'h0000, 1'b0, rd, v);
    `CHK("status", 16'h0000, rd)
    `CHK("irq", 1'b0, irqReq_r)
    host.op(RD, 8'h6e, 16'h0000, 1'b1, rd, v);
    `CHK("other addr", 1'b0, v)
    host.op(WR, KA, 16'h1234, 1'b1, rd, v);
    host.op(RD, KA, 16'h0000, 1'b1, rd, v);
    `CHK("ticker read", 16'h0000, rd)
    host.op(SNS, KA, 16'h0000, 1'b0, rd, v);
    `CHK("ticker sense", 16'h0000, rd)
    `CHK("ticker valid", 1'b1, v)
    $display("test basic done");
  endtask
  task automatic t_period(input logic [3:0] nib, input int per);
    int n;
    host.op(WR, TA, {nib, 12'h002}, 1'b1, rd, v);
    host.op(CMD, TA, 16'h0060, 1'b0, rd, v);
    wait_irq(2 * per + 20, n);
    `CHK("irq", 1'b1, irqReq_r)
    `CHK("irq dev", TA, irqDev_r)
    host.op(ACK, 8'h00, 16'h0000, 1'b0, rd, v);
    `CHK("ack data", {8'h00, TA}, rd)
    `CHK("irq clear", 1'b0, irqReq_r)
    wait_irq(per, n);
    `CHK("period", per, n + 2)
    host.op(ACK, 8'h00, 16'h0000, 1'b0, rd, v);
    $display("test period %0h done", nib);
  endtask
  task automatic t_overrun();
    host.wr2(TA, 16'h1002);
    host.op(CMD, TA, 16'h0060, 1'b0, rd, v);
    host.op(WR, TA, 16'h0010, 1'b0, rd, v);
    repeat (40) @(negedge clock);
    host.op(SNS, TA, 16'h0000, 1'b0, rd, v);
    `CHK("overrun", 16'h0008, rd)
    host.op(SNS, TA, 16'h0000, 1'b0, rd, v);
    `CHK("overrun clear", 16'h0000, rd)
    host.op(RD, TA, 16'h0000, 1'b1, rb, v);
    repeat (48) @(negedge clock);
    host.op(RD, TA, 16'h0000, 1'b1, rd, v);
    `CHK("stopped", rb, rd)
    host.op(WR, TA, 16'h0002, 1'b0, rd, v);
    host.op(ACK, 8'h00, 16'h0000, 1'b0, rd, v);
    $display("test overrun done");
  endtask
  task automatic t_prio();
    int n;
    host.op(WR, TA, 16'h1002, 1'b1, rd, v);
    host.op(CMD, TA, 16'h00a0, 1'b0, rd, v);
    repeat (40) @(negedge clock);
    `CHK("masked", 1'b0, irqReq_r)
    host.op(CMD, KA, 16'h0040, 1'b0, rd, v);
    acLine = ~acLine;
    wait_irq(10, n);
    `CHK("ticker dev", KA, irqDev_r)
    host.op(CMD, TA, 16'h0040, 1'b0, rd, v);
    repeat (2) @(negedge clock);
    `CHK("priority", TA, irqDev_r)
    host.op(ACK, 8'h00, 16'h0000, 1'b0, rd, v);
    `CHK("ack first", {8'h00, TA}, rd)
    host.op(CMD, TA, 16'h0080, 1'b0, rd, v);
    repeat (2) @(negedge clock);
    `CHK("ticker left", KA, irqDev_r)
    host.op(ACK, 8'h00, 16'h0000, 1'b0, rd, v);
    `CHK("ack second", {8'h00, KA}, rd)
    host.op(CMD, KA, 16'h0080, 1'b0, rd, v);
    acLine = ~acLine;
    repeat (10) @(negedge clock);
    `CHK("ticker masked", 1'b0, irqReq_r)
    host.op(CMD, KA, 16'h0040, 1'b0, rd, v);
    repeat (2) @(negedge clock);
    `CHK("ticker kept", 1'b1, irqReq_r)
    host.op(ACK, 8'h00, 16'h0000, 1'b0, rd, v);
    $display("test priority done");
  endtask
  task automatic t_stop();
    host.op(WR, TA, 16'h0002, 1'b1, rd, v);
    host.op(CMD, TA, 16'h0060, 1'b0, rd, v);
    host.op(RD, TA, 16'h0000, 1'b1, rb, v);
    `CHK("read top", 4'h0, rb[15:12])
    `CHK("stop count", 16'h0002, rb)
    repeat (50) @(negedge clock);
    host.op(RD, TA, 16'h0000, 1'b0, rd, v);
    `CHK("read hi", 16'h0000, rd)
    host.op(RD, TA, 16'h0000, 1'b0, rd, v);
    `CHK("read lo", 16'h0002, rd)
    $display("test stop done");
  endtask
  task automatic t_init();
    host.op(WR, TA, 16'h1002, 1'b1, rd, v);
    host.op(CMD, TA, 16'h0060, 1'b0, rd, v);
    host.op(RD, TA, 16'h0000, 1'b0, rd, v);
    rst_n = 1'b0;
    @(negedge clock);
    rst_n = 1'b1;
    `CHK("init irq", 1'b0, irqReq_r)
    host.op(CMD, TA, 16'h0040, 1'b0, rd, v);
    repeat (40) @(negedge clock);
    `CHK("init stopped", 1'b0, irqReq_r)
    host.op(SNS, TA, 16'h0000, 1'b0, rd, v);
    `CHK("init status", 16'h0000, rd)
    host.op(WR, TA, 16'h1234, 1'b1, rd, v);
    host.op(CMD, TA, 16'h0020, 1'b0, rd, v);
    host.op(RD, TA, 16'h0000, 1'b0, rd, v);
    `CHK("init byte flag", 16'h0002, rd)
    host.op(RD, TA, 16'h0000, 1'b0, rd, v);
    host.op(WR, TA, 16'h0000, 1'b1, rd, v);
    host.op(CMD, TA, 16'h0020, 1'b0, rd, v);
    $display("test init done");
  endtask
  task automatic t_ext();
    int n;
    useExt <= 1'b1;
    repeat (10) @(negedge clock);
    host.op(WR, TA, 16'h1002, 1'b1, rd, v);
    host.op(CMD, TA, 16'h0060, 1'b0, rd, v);
    wait_irq(120, n);
    host.op(ACK, 8'h00, 16'h0000, 1'b0, rd, v);
    wait_irq(80, n);
    `CHK("ext period", 40, n + 2)
    host.op(ACK, 8'h00, 16'h0000, 1'b0, rd, v);
    host.op(WR, TA, 16'h0000, 1'b1, rd, v);
    host.op(CMD, TA, 16'h0020, 1'b0, rd, v);
    useExt <= 1'b0;
    $display("test external done");
  endtask
  task wrap_up();
    $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  initial begin
    clock = 1'b0;
    forever #(ILC_CLK_PERIOD_NS / 2) clock = ~clock;
  end
  initial begin
    #(ILC_CLK_PERIOD_NS * 90000);
    n_mismatch++;
    wrap_up();
  end
  initial begin
    rst_n  = 1'b0;
    acLine = 1'b0;
    repeat (3) @(negedge clock);
    rst_n = 1'b1;
    t_basic();
    t_period(4'h1, 20);
    t_period(4'h3, 200);
    t_period(4'h6, 2000);
    t_period(4'h8, 20000);
    t_overrun();
    t_prio();
    t_stop();
    t_init();
    t_ext();
    wrap_up();
  end
endmodule
